// *** rtl/fpr_consts.vh ***
`ifndef FPR_CONSTS_VH
`define FPR_CONSTS_VH

// ****************************************
// command kinds from the opcode decoder
// ****************************************
`define FPR_CMD_W          3
`define FPR_CMD_OTHER      3'h0
`define FPR_CMD_PROGRAM    3'h1
`define FPR_CMD_ERASE      3'h2
`define FPR_CMD_MAP_WRITE  3'h3
`define FPR_CMD_PROT_ON    3'h4
`define FPR_CMD_PROT_OFF   3'h5
`define FPR_CMD_LOCK       3'h6
`define FPR_CMD_QUAD_READ  3'h7
`define FPR_CMD_QUAD_EN_W  1

// ****************************************
// sector map
// ****************************************
`define FPR_SECT_W         4
`define FPR_SECT_N         16
`define FPR_MAP_RESET      16'h0000

// ****************************************
// state codes
// ****************************************
`define FPR_ST_W           2
`define FPR_ST_IDLE        2'h0
`define FPR_ST_DISCARD     2'h1
`define FPR_ST_BUSY        2'h2
`define FPR_ST_QREAD       2'h3

`endif

// *** rtl/fpr_pad.v ***
`timescale 1ns/1ps
`include "fpr_consts.vh"

// ****************************************
// shared pad: weak pull-up input, data output
// ****************************************
module fpr_pad (
  // clock and reset
  input  wire core_clk,
  input  wire resetn,
  // core side
  input  wire drive_en,
  input  wire drive_load,
  input  wire drive_val,
  output reg  level,
  // pin side
  input  wire pin_in,
  input  wire pin_driven,
  output reg  pin_out,
  output reg  pin_oe
);

  always @(posedge core_clk) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      level   <= 1'b1;
    end else begin
      pin_oe <= drive_en;
      if (!drive_en)
        pin_out <= 1'b0;
      else if (drive_load)
        pin_out <= drive_val;
      // a floating pin reads high; not sampled while driving
      if (!drive_en && !pin_oe)
        level <= pin_driven ? pin_in : 1'b1;
    end
  end

endmodule

// *** rtl/fpr_prot_map.v ***
`timescale 1ns/1ps
`include "fpr_consts.vh"

// ****************************************
// protected-sector map, lock map, soft enable
// ****************************************
module fpr_prot_map (
  // clock and reset
  input  wire                    core_clk,
  input  wire                    resetn,
  // updates
  input  wire                    map_load,
  input  wire [`FPR_SECT_N-1:0]  map_data,
  input  wire                    prot_on,
  input  wire                    prot_off,
  input  wire                    lock_set,
  input  wire [`FPR_SECT_W-1:0]  sector,
  input  wire                    wp_asserted,
  // state
  output reg  [`FPR_SECT_N-1:0]  prot_map,
  output reg  [`FPR_SECT_N-1:0]  lock_map,
  output reg                     soft_prot_en,
  output wire                    sector_blocked
);

  always @(posedge core_clk) begin
    if (!resetn) begin
      prot_map     <= `FPR_MAP_RESET;
      soft_prot_en <= 1'b0;
    end else begin
      if (map_load && !wp_asserted)
        prot_map <= map_data;
      if (prot_on)
        soft_prot_en <= 1'b1;
      else if (prot_off && !wp_asserted)
        soft_prot_en <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `FPR_SECT_N; i = i + 1) begin : g_lock
      always @(posedge core_clk) begin
        if (!resetn)
          lock_map[i] <= 1'b0;
        else if (lock_set && (sector == i))
          lock_map[i] <= 1'b1;
      end
    end
  endgenerate

  // hardware pin protects the map regardless of the soft enable
  assign sector_blocked = lock_map[sector] |
                          (prot_map[sector] & (soft_prot_en | wp_asserted));

endmodule

// *** rtl/fpr_protect_reset.v ***
`timescale 1ns/1ps
`include "fpr_consts.vh"

module fpr_protect_reset (
  // clock and power-on reset
  input  wire                    core_clk,
  input  wire                    resetn,
  // chip select
  input  wire                    cs_n,
  // command decoder
  input  wire                    cmd_valid,
  input  wire [`FPR_CMD_W-1:0]   cmd_kind,
  input  wire [`FPR_SECT_W-1:0]  cmd_sector,
  input  wire [`FPR_SECT_N-1:0]  cmd_map_data,
  input  wire                    cmd_quad_enable,
  // operation engine
  input  wire                    op_done,
  output reg                     op_start,
  output reg  [`FPR_CMD_W-1:0]   op_kind,
  output reg                     op_abort,
  // quad read data, one strobe per falling serial clock
  input  wire                    quad_nibble_strobe,
  input  wire [3:0]              quad_nibble,
  // write-protect pin, data line 2
  input  wire                    quad_data_line_2_in,
  input  wire                    quad_data_line_2_driven,
  output wire                    quad_data_line_2_out,
  output wire                    quad_data_line_2_oe,
  // reset pin, data line 3
  input  wire                    quad_data_line_3_in,
  input  wire                    quad_data_line_3_driven,
  output wire                    quad_data_line_3_out,
  output wire                    quad_data_line_3_oe,
  // status
  output reg  [`FPR_ST_W-1:0]    state,
  output reg                     cmd_dropped,
  output reg                     quad_io_enable_bit,
  output reg                     wp_asserted,
  output reg                     pin_reset_active,
  output reg  [`FPR_SECT_N-1:0]  prot_map,
  output reg  [`FPR_SECT_N-1:0]  lock_map,
  output reg                     soft_prot_en
);

  localparam ST_IDLE    = `FPR_ST_IDLE;
  localparam ST_DISCARD = `FPR_ST_DISCARD;
  localparam ST_BUSY    = `FPR_ST_BUSY;
  localparam ST_QREAD   = `FPR_ST_QREAD;

  reg  [`FPR_ST_W-1:0]   next_state;
  reg                    next_op_start;
  reg                    next_dropped;
  wire                   wp_level;
  wire                   rst_level;
  wire                   drive_lines;
  wire                   in_quad;
  wire                   take;
  wire                   is_prog_erase;
  wire                   blocked;
  wire [`FPR_SECT_N-1:0] map_now;
  wire [`FPR_SECT_N-1:0] lock_now;
  wire                   soft_now;

  // ****************************************
  // pin functions
  // ****************************************
  assign in_quad       = (state == ST_QREAD);
  assign drive_lines   = in_quad && !cs_n && quad_io_enable_bit;
  assign take          = cmd_valid && !cs_n && (state == ST_IDLE) && !pin_reset_active;
  assign is_prog_erase = (cmd_kind == `FPR_CMD_PROGRAM) || (cmd_kind == `FPR_CMD_ERASE);

  fpr_pad u_pad_wp (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .drive_en   (drive_lines),
    .drive_load (quad_nibble_strobe),
    .drive_val  (quad_nibble[2]),
    .level      (wp_level),
    .pin_in     (quad_data_line_2_in),
    .pin_driven (quad_data_line_2_driven),
    .pin_out    (quad_data_line_2_out),
    .pin_oe     (quad_data_line_2_oe)
  );

  fpr_pad u_pad_rst (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .drive_en   (drive_lines),
    .drive_load (quad_nibble_strobe),
    .drive_val  (quad_nibble[3]),
    .level      (rst_level),
    .pin_in     (quad_data_line_3_in),
    .pin_driven (quad_data_line_3_driven),
    .pin_out    (quad_data_line_3_out),
    .pin_oe     (quad_data_line_3_oe)
  );

  // ****************************************
  // protection maps
  // ****************************************
  fpr_prot_map u_map (
    .core_clk       (core_clk),
    .resetn         (resetn),
    .map_load       (take && (cmd_kind == `FPR_CMD_MAP_WRITE)),
    .map_data       (cmd_map_data),
    .prot_on        (take && (cmd_kind == `FPR_CMD_PROT_ON)),
    .prot_off       (take && (cmd_kind == `FPR_CMD_PROT_OFF)),
    .lock_set       (take && (cmd_kind == `FPR_CMD_LOCK)),
    .sector         (cmd_sector),
    .wp_asserted    (wp_asserted),
    .prot_map       (map_now),
    .lock_map       (lock_now),
    .soft_prot_en   (soft_now),
    .sector_blocked (blocked)
  );

  // ****************************************
  // command state machine
  // ****************************************
  always @* begin
    next_state    = state;
    next_op_start = 1'b0;
    next_dropped  = cmd_dropped;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_dropped = 1'b0;
          if (is_prog_erase) begin
            if (wp_asserted || blocked) begin
              next_state   = ST_DISCARD;
              next_dropped = 1'b1;
            end else begin
              next_state    = ST_BUSY;
              next_op_start = 1'b1;
            end
          end else if ((cmd_kind == `FPR_CMD_QUAD_READ) && quad_io_enable_bit) begin
            next_state = ST_QREAD;
          end
        end
      end
      ST_DISCARD: begin
        if (cs_n)
          next_state = ST_IDLE;
      end
      ST_BUSY: begin
        if (op_done)
          next_state = ST_IDLE;
      end
      ST_QREAD: begin
        if (cs_n)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      state              <= ST_IDLE;
      op_start           <= 1'b0;
      op_kind            <= `FPR_CMD_OTHER;
      op_abort           <= 1'b0;
      cmd_dropped        <= 1'b0;
      quad_io_enable_bit <= 1'b0;
      wp_asserted        <= 1'b0;
      pin_reset_active   <= 1'b0;
      prot_map           <= `FPR_MAP_RESET;
      lock_map           <= `FPR_MAP_RESET;
      soft_prot_en       <= 1'b0;
    end else begin
      // pins are ignored as inputs while they carry read data
      wp_asserted      <= !wp_level && !drive_lines && !quad_data_line_2_oe;
      pin_reset_active <= !rst_level && !drive_lines && !quad_data_line_3_oe;
      prot_map         <= map_now;
      lock_map         <= lock_now;
      soft_prot_en     <= soft_now;
      if (take && cmd_quad_enable)
        quad_io_enable_bit <= 1'b1;
      if (pin_reset_active) begin
        state    <= ST_IDLE;
        op_start <= 1'b0;
        op_abort <= (state != ST_IDLE);
      end else begin
        state    <= next_state;
        op_start <= next_op_start;
        op_abort <= 1'b0;
        if (next_op_start)
          op_kind <= cmd_kind;
      end
      cmd_dropped <= pin_reset_active ? cmd_dropped : next_dropped;
    end
  end

endmodule

// *** test/fpr_monitor.sv ***
`timescale 1ns/1ps
`include "fpr_consts.vh"
module fpr_monitor (
  // clock and reset
  input wire                   core_clk,
  input wire                   resetn,
  // inputs
  input wire                   cs_n,
  input wire                   cmd_valid,
  input wire [`FPR_CMD_W-1:0]  cmd_kind,
  input wire [`FPR_SECT_W-1:0] cmd_sector,
  input wire                   quad_nibble_strobe,
  input wire [3:0]             quad_nibble,
  input wire                   quad_data_line_2_driven,
  // outputs
  input wire                   quad_data_line_2_out,
  input wire                   quad_data_line_2_oe,
  input wire                   quad_data_line_3_out,
  input wire                   quad_data_line_3_oe,
  input wire                   op_start,
  input wire [`FPR_ST_W-1:0]   state,
  input wire                   quad_io_enable_bit,
  input wire                   wp_asserted,
  input wire                   pin_reset_active,
  input wire [`FPR_SECT_N-1:0] prot_map,
  input wire [`FPR_SECT_N-1:0] lock_map
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire take = cmd_valid && !cs_n && state == `FPR_ST_IDLE && !pin_reset_active;
  wire pe   = cmd_kind == `FPR_CMD_PROGRAM || cmd_kind == `FPR_CMD_ERASE;
  wire qrd  = state == `FPR_ST_QREAD;
  a_wp_drops_cmd: assert property (
    take && pe && wp_asserted |=> !op_start && state == `FPR_ST_DISCARD) else $error("protected command started");
  a_discard_idle: assert property (
    state == `FPR_ST_DISCARD && cs_n |=> state == `FPR_ST_IDLE) else $error("discard not left");
  a_map_frozen: assert property (
    wp_asserted && $past(wp_asserted) && $past(wp_asserted, 2) |-> $stable(prot_map)) else $error("map changed");
  a_lock_under_wp: assert property (
    take && wp_asserted && cmd_kind == `FPR_CMD_LOCK |-> ##2 lock_map[$past(cmd_sector, 2)])
    else $error("lock refused");
  a_wp_pull_up: assert property (
    (!quad_data_line_2_driven && !quad_data_line_2_oe)[*4] |-> !wp_asserted) else $error("floating pin asserted");
  a_quad_data_out: assert property (
    qrd && !cs_n && quad_nibble_strobe |=> quad_data_line_2_out == $past(quad_nibble[2])
      && quad_data_line_3_out == $past(quad_nibble[3])) else $error("quad data wrong");
  a_quad_needs_qe: assert property (
    quad_data_line_2_oe || quad_data_line_3_oe || qrd |-> quad_io_enable_bit) else $error("pins driven without qe");
  a_reset_pin_idle: assert property (
    pin_reset_active |=> state == `FPR_ST_IDLE && !op_start) else $error("not idle under reset pin");
  a_quad_release: assert property (
    qrd && cs_n |-> ##2 !quad_data_line_2_oe && !quad_data_line_3_oe) else $error("pins not released");
  a_power_on_clear: assert property (
    $rose(resetn) |-> state == `FPR_ST_IDLE && prot_map == `FPR_MAP_RESET && !quad_io_enable_bit)
    else $error("bad init");
  c_dropped: cover property (take && pe && wp_asserted);
  c_quad: cover property (qrd ##1 quad_nibble_strobe);
  c_rst_pin: cover property ($rose(pin_reset_active));
endmodule
bind fpr_protect_reset fpr_monitor u_mon (.*);

// *** test/fpr_host_model.sv ***
`timescale 1ns/1ps
module fpr_host_model (
  // host requests
  input  wire wp_drive,
  input  wire wp_val,
  input  wire rst_val,
  // device pins
  input  wire l2_out,
  input  wire l2_oe,
  input  wire l3_out,
  input  wire l3_oe,
  output wire l2_in,
  output wire l2_driven,
  output wire l3_in,
  output wire l3_driven
);
  // host yields a line whenever the device drives it
  assign l2_driven = wp_drive && !l2_oe;
  // an undriven line carries no level of its own; only the device pull-up may read it high
  assign l2_in     = l2_oe ? l2_out : (l2_driven ? wp_val : 1'b0);
  assign l3_driven = !l3_oe;
  assign l3_in     = l3_oe ? l3_out : rst_val;
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
`include "fpr_consts.vh"
module testbench;
  logic core_clk = 0, resetn = 0, cs_n = 1, cmd_valid = 0, cmd_quad_enable = 0, op_done = 0, quad_nibble_strobe = 0;
  logic [2:0] cmd_kind = 0;
  logic [3:0] cmd_sector = 0, quad_nibble = 0;
  logic [15:0] cmd_map_data = 0, m_prot = 0, m_lock = 0;
  logic wp_drive = 1, wp_val = 1, rst_val = 1, m_soft = 0, drop, aborted = 0;
  wire op_start, op_abort, l2i, l2d, l2o, l2e, l3i, l3d, l3o, l3e, cmd_dropped, qe, wp_asserted, pin_reset_active;
  wire soft_prot_en;
  wire [2:0] op_kind;
  wire [1:0] state;
  wire [15:0] prot_map, lock_map;
  integer mismatches = 0, comparisons = 0, cyc = 0, i, k;
  logic [31:0] rng = 32'hF964;
  fpr_protect_reset dut (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_sector(cmd_sector), .cmd_map_data(cmd_map_data), .cmd_quad_enable(cmd_quad_enable),
    .op_done(op_done), .op_start(op_start), .op_kind(op_kind), .op_abort(op_abort),
    .quad_nibble_strobe(quad_nibble_strobe), .quad_nibble(quad_nibble), .quad_data_line_2_in(l2i),
    .quad_data_line_2_driven(l2d), .quad_data_line_2_out(l2o), .quad_data_line_2_oe(l2e),
    .quad_data_line_3_in(l3i), .quad_data_line_3_driven(l3d), .quad_data_line_3_out(l3o),
    .quad_data_line_3_oe(l3e), .state(state), .cmd_dropped(cmd_dropped), .quad_io_enable_bit(qe),
    .wp_asserted(wp_asserted), .pin_reset_active(pin_reset_active), .prot_map(prot_map), .lock_map(lock_map),
    .soft_prot_en(soft_prot_en));
  fpr_host_model host (.wp_drive(wp_drive), .wp_val(wp_val), .rst_val(rst_val), .l2_out(l2o), .l2_oe(l2e),
    .l3_out(l3o), .l3_oe(l3e), .l2_in(l2i), .l2_driven(l2d), .l3_in(l3i), .l3_driven(l3d));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (op_abort === 1'b1) aborted <= 1'b1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  function logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task step(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cmd(input logic [2:0] kd, input logic [3:0] s, input logic [15:0] m, input logic q);
    cmd_valid = 1;
    cmd_kind = kd;
    cmd_sector = s;
    cmd_map_data = m;
    cmd_quad_enable = q;
    step(1);
    cmd_valid = 0;
    cmd_quad_enable = 0;
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    step(3);
    resetn = 1;
    cs_n = 0;
    cmd(7, 0, 0, 0);
    chk("quad_no_qe", 0, state);
    step(1);
    cmd(0, 0, 0, 1);
    step(1);
    chk("qe", 1, qe);
    cmd(7, 0, 0, 0);
    chk("qread", 3, state);
    step(1);
    chk("oe", 3, {l3e, l2e});
    for (i = 0; i < 6; i = i + 1) begin
      rng = xs(rng);
      quad_nibble = rng[3:0];
      quad_nibble_strobe = 1;
      step(1);
      quad_nibble_strobe = 0;
      step(1);
      chk("data", quad_nibble[3:2], {l3o, l2o});
    end
    cs_n = 1;
    step(3);
    chk("release", 0, {l3e, l2e});
    cs_n = 0;
    wp_drive = 0;
    step(5);
    chk("wp_float", 0, wp_asserted);
    wp_drive = 1;
    cmd(1, 0, 0, 0);
    chk("busy", 2, state);
    rst_val = 0;
    step(4);
    chk("abort", 1, aborted);
    chk("rst_active", 1, pin_reset_active);
    cmd(1, 0, 0, 0);
    chk("rst_hold", 0, state);
    rst_val = 1;
    step(4);
    chk("rst_clear", 0, pin_reset_active);
    cmd(2, 3, 0, 0);
    chk("resume", 2, state);
    op_done = 1;
    step(1);
    op_done = 0;
    for (i = 0; i < 60; i = i + 1) begin
      rng = xs(rng);
      wp_val = rng[8] | rng[9];
      step(4);
      k = rng[2:0] % 6 + 1;
      cmd(k[2:0], rng[7:4], rng[31:16], 0);
      if (k < 3) begin
        drop = !wp_val || m_lock[rng[7:4]] || (m_prot[rng[7:4]] && m_soft);
        chk("state", drop ? 1 : 2, state);
        chk("start", !drop, op_start);
        chk("dropped", drop, cmd_dropped);
        if (!drop) chk("kind", k[2:0], op_kind);
        op_done = !drop;
        step(1);
        op_done = 0;
      end
      case (k)
        3: if (wp_val) m_prot = rng[31:16];
        4: m_soft = 1;
        5: if (wp_val) m_soft = 0;
        6: m_lock[rng[7:4]] = 1;
        default: ;
      endcase
      cs_n = 1;
      step(1);
      chk("idle", 0, state);
      cs_n = 0;
      step(2);
      chk("prot", m_prot, prot_map);
      chk("lock", m_lock, lock_map);
      chk("soft", m_soft, soft_prot_en);
    end
    stop_test;
  end
endmodule
